// ===== ovl_regs.sv
// Indexed register bank for the secondary window, cursor and capture port.
// Assumes a synchronous host I/O strobe interface on clk_i and strap pins
// that are stable around reset release.
`timescale 1ns/1ps
`default_nettype none
`include "ovl_cfg.svh"

// Functional notes
// - Write index, then access data port.
// - One index port serves both groups.
// - Straps latched after reset release set port digit.
// - Window row pitch 12-bit quadwords, two registers.
// - Pan bit 7 flags last line.
// - Pan bit 6 mirrors display-enable pin.
// - Pan value shifts pixels left, nine-dot.
// - Zoom field repeats each line 1-4.
// - Depth codes pick 1 to 16 bpp.
// - Control bit 2 selects cursor size.
// - Control bit 1 overlay or cursor pins.
// - Control bit 0 selects window or cursor.
// - Capture start is 20-bit doubleword offset.
// - Capture line length 12-bit doublewords.
// - Capture control bit 7 enables overlay.
// - Capture control bit 1 selects interlace.
// - Capture control bit 0 enables port.
// - Control enable bits clear on reset.
module ovl_regs (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	// Host I/O bus
	input  wire logic [15:0]   io_addr_i,
	input  wire logic          io_wr_i,
	input  wire logic          io_rd_i,
	input  wire logic [7:0]    io_wdata_i,
	output logic [7:0]         io_rdata_o,
	output logic               io_ack_o,
	// Strap and display pins
	input  wire logic [2:0]    io_base_strap_pins_i,
	input  wire logic          secondary_display_enable_pin_i,
	input  wire logic          last_line_i,
	input  wire logic          nine_dot_i,
	input  wire logic [1:0]    cursor_pixel_i,
	// Overlay settings
	output logic [11:0]        window_pitch_o,
	output logic [3:0]         pan_shift_o,
	output logic [2:0]         line_repeat_o,
	output ovl_pkg::depth_e    depth_o,
	output logic               depth_valid_o,
	output logic               cursor_big_o,
	output logic               overlay_mode_o,
	output logic [1:0]         cursor_pixel_pins_o,
	output logic               window_sel_o,
	output logic               window_en_o,
	output logic               cursor_en_o,
	// Capture port settings
	output logic [19:0]        cap_start_dword_o,
	output logic [21:0]        cap_start_byte_o,
	output logic [11:0]        cap_length_o,
	output logic [11:0]        cap_pitch_o,
	output logic               cap_interlace_o,
	output logic               cap_port_en_o
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0]  strap_meta;
	logic [2:0]  strap_sync;
	logic [1:0]  disp_en_meta;
	logic [1:0]  last_meta;
	logic        disp_en_sync;
	logic        last_sync;
	logic [1:0]  cursor_meta;
	logic [1:0]  cursor_sync;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			strap_meta   <= 3'h0;
			strap_sync   <= 3'h0;
			disp_en_meta <= 2'h0;
			last_meta    <= 2'h0;
			cursor_meta  <= 2'h0;
			cursor_sync  <= 2'h0;
			disp_en_sync <= 1'b0;
			last_sync    <= 1'b0;
		end else if (ce_i) begin
			strap_meta   <= io_base_strap_pins_i;
			strap_sync   <= strap_meta;
			disp_en_meta <= {disp_en_meta[0], secondary_display_enable_pin_i};
			last_meta    <= {last_meta[0], last_line_i};
			cursor_meta  <= cursor_pixel_i;
			cursor_sync  <= cursor_meta;
			disp_en_sync <= disp_en_meta[1];
			last_sync    <= last_meta[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strap capture after reset release

	// Capture waits for the synchroniser to fill, so reset takes a constant
	logic [1:0]  strap_wait;
	logic        strap_done;
	logic [2:0]  io_digit;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			strap_wait <= 2'h0;
			strap_done <= 1'b0;
			io_digit   <= 3'h0;
		end else if (ce_i && !strap_done) begin
			if (strap_wait == 2'h3) begin
				io_digit   <= strap_sync;
				strap_done <= 1'b1;
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic port_hit(input logic [15:0] addr, input logic [2:0] digit,
		input logic [3:0] low);
		port_hit = (addr == {`IO_PREFIX, 1'b0, digit, low});
	endfunction

	logic        hit_index;
	logic        hit_data;
	logic        wr_data;
	logic [7:0]  index_reg;

	assign hit_index = strap_done && port_hit(io_addr_i, io_digit, `IO_INDEX_LOW);
	assign hit_data  = strap_done && port_hit(io_addr_i, io_digit, `IO_DATA_LOW);
	assign wr_data   = ce_i && io_wr_i && hit_data;

	// One index serves both register groups
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			index_reg <= `RESET_INDEX;
		end else if (ce_i && io_wr_i && hit_index) begin
			index_reg <= io_wdata_i;
		end
	end

	function automatic logic sel(input logic [7:0] idx);
		sel = (index_reg == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Overlay registers

	logic [7:0]  pitch_low;
	logic [3:0]  pitch_high;
	logic [2:0]  pan_code;
	logic [7:0]  depth_zoom;
	logic [2:0]  ovl_control;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pitch_low   <= `RESET_BYTE;
			pitch_high  <= 4'h0;
			pan_code    <= 3'h0;
			depth_zoom  <= `RESET_BYTE;
			ovl_control <= 3'h0;
		end else if (wr_data) begin
			if (sel(`IDX_PITCH_LOW))
				pitch_low <= io_wdata_i;
			if (sel(`IDX_PITCH_HIGH))
				pitch_high <= io_wdata_i[3:0];
			if (sel(`IDX_PAN_STATUS))
				pan_code <= io_wdata_i[2:0];
			if (sel(`IDX_DEPTH_ZOOM))
				depth_zoom <= io_wdata_i & `MASK_DEPTH_ZOOM;
			if (sel(`IDX_OVL_CONTROL))
				ovl_control <= io_wdata_i[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture port registers

	logic [19:0] cap_start;
	logic [11:0] cap_length;
	logic [11:0] cap_pitch;
	logic [7:0]  cap_control;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cap_start   <= 20'h0;
			cap_length  <= 12'h0;
			cap_pitch   <= 12'h0;
			cap_control <= `RESET_BYTE;
		end else if (wr_data) begin
			if (sel(`IDX_CAP_START_L))
				cap_start[7:0] <= io_wdata_i;
			if (sel(`IDX_CAP_START_M))
				cap_start[15:8] <= io_wdata_i;
			if (sel(`IDX_CAP_START_H))
				cap_start[19:16] <= io_wdata_i[3:0];
			if (sel(`IDX_CAP_LEN_L))
				cap_length[7:0] <= io_wdata_i;
			if (sel(`IDX_CAP_LEN_H))
				cap_length[11:8] <= io_wdata_i[3:0];
			if (sel(`IDX_CAP_PITCH_L))
				cap_pitch[7:0] <= io_wdata_i;
			if (sel(`IDX_CAP_PITCH_H))
				cap_pitch[11:8] <= io_wdata_i[3:0];
			if (sel(`IDX_CAP_CONTROL))
				cap_control <= io_wdata_i & `MASK_CAP_CONTROL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [7:0]  read_mux;

	always_comb begin
		unique case (index_reg)
			`IDX_PITCH_LOW:   read_mux = pitch_low;
			`IDX_PITCH_HIGH:  read_mux = {4'h0, pitch_high};
			`IDX_PAN_STATUS:  read_mux = {last_sync, disp_en_sync, 3'h0, pan_code};
			`IDX_DEPTH_ZOOM:  read_mux = depth_zoom;
			`IDX_OVL_CONTROL: read_mux = {5'h00, ovl_control};
			`IDX_CAP_START_L: read_mux = cap_start[7:0];
			`IDX_CAP_START_M: read_mux = cap_start[15:8];
			`IDX_CAP_START_H: read_mux = {4'h0, cap_start[19:16]};
			`IDX_CAP_LEN_L:   read_mux = cap_length[7:0];
			`IDX_CAP_LEN_H:   read_mux = {4'h0, cap_length[11:8]};
			`IDX_CAP_PITCH_L: read_mux = cap_pitch[7:0];
			`IDX_CAP_PITCH_H: read_mux = {4'h0, cap_pitch[11:8]};
			`IDX_CAP_CONTROL: read_mux = cap_control;
			default:          read_mux = 8'h00;
		endcase
	end

	// Data is held one cycle after the strobe; ack marks it
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			io_rdata_o <= 8'h00;
			io_ack_o   <= 1'b0;
		end else if (ce_i) begin
			io_ack_o <= (io_rd_i || io_wr_i) && (hit_index || hit_data);
			if (io_rd_i && hit_index)
				io_rdata_o <= index_reg;
			else if (io_rd_i && hit_data)
				io_rdata_o <= read_mux;
			else
				io_rdata_o <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded settings

	ovl_pkg::depth_e next_depth;
	logic            next_depth_valid;
	logic [2:0]      next_line_repeat;
	logic [3:0]      next_pan_shift;

	ovl_decode u_decode (
		.depth_code_i  (depth_zoom[3:0]),
		.zoom_code_i   (depth_zoom[`ZOOM_MSB:`ZOOM_LSB]),
		.pan_code_i    (pan_code),
		.nine_dot_i    (nine_dot_i),
		.depth_o       (next_depth),
		.depth_valid_o (next_depth_valid),
		.line_repeat_o (next_line_repeat),
		.pan_shift_o   (next_pan_shift)
	);

	logic ovl_on;
	assign ovl_on = cap_control[`CAP_OVL_EN_BIT];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			window_pitch_o      <= 12'h0;
			pan_shift_o         <= 4'h0;
			line_repeat_o       <= 3'h1;
			depth_o             <= ovl_pkg::DEPTH_1;
			depth_valid_o       <= 1'b1;
			cursor_big_o        <= 1'b0;
			overlay_mode_o      <= 1'b0;
			cursor_pixel_pins_o <= 2'h0;
			window_sel_o        <= 1'b0;
			window_en_o         <= 1'b0;
			cursor_en_o         <= 1'b0;
		end else if (ce_i) begin
			window_pitch_o <= {pitch_high, pitch_low};
			pan_shift_o    <= next_pan_shift;
			line_repeat_o  <= next_line_repeat;
			depth_o        <= next_depth;
			depth_valid_o  <= next_depth_valid;
			cursor_big_o   <= ovl_control[`CTL_CURSOR_BIG_BIT];
			overlay_mode_o <= ovl_control[`CTL_OVERLAY_BIT];
			// Pins carry cursor pixels only in output mode
			cursor_pixel_pins_o <= ovl_control[`CTL_OVERLAY_BIT] ? 2'h0 : cursor_sync;
			window_sel_o   <= ovl_control[`CTL_WINDOW_SEL_BIT];
			window_en_o    <= ovl_on && ovl_control[`CTL_WINDOW_SEL_BIT];
			cursor_en_o    <= ovl_on && !ovl_control[`CTL_WINDOW_SEL_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cap_start_dword_o <= 20'h0;
			cap_start_byte_o  <= 22'h0;
			cap_length_o      <= 12'h0;
			cap_pitch_o       <= 12'h0;
			cap_interlace_o   <= 1'b0;
			cap_port_en_o     <= 1'b0;
		end else if (ce_i) begin
			cap_start_dword_o <= cap_start;
			cap_start_byte_o  <= {cap_start, 2'b00};
			cap_length_o      <= cap_length;
			cap_pitch_o       <= cap_pitch;
			cap_interlace_o   <= cap_control[`CAP_INTERLACE_BIT];
			cap_port_en_o     <= cap_control[`CAP_PORT_EN_BIT];
		end
	end

endmodule

`default_nettype wire

// ===== ovl_cfg.svh
// Constants for the overlay and image capture port register bank.
// Assumes inclusion by bare name from files in the same folder.
`ifndef OVL_CFG_SVH
`define OVL_CFG_SVH

// I/O port addressing: 0x21xA index, 0x21xB data, x from straps
`define IO_PREFIX        8'h21
`define IO_INDEX_LOW     4'ha
`define IO_DATA_LOW      4'hb

// Indexed register numbers
`define IDX_PITCH_LOW    8'heb
`define IDX_PITCH_HIGH   8'hec
`define IDX_PAN_STATUS   8'hed
`define IDX_DEPTH_ZOOM   8'hee
`define IDX_OVL_CONTROL  8'hef
`define IDX_CAP_START_L  8'hf0
`define IDX_CAP_START_M  8'hf1
`define IDX_CAP_START_H  8'hf2
`define IDX_CAP_LEN_L    8'hf3
`define IDX_CAP_LEN_H    8'hf4
`define IDX_CAP_PITCH_L  8'hf5
`define IDX_CAP_PITCH_H  8'hf6
`define IDX_CAP_CONTROL  8'hf7

// Field positions
`define PAN_LAST_LINE_BIT   7
`define PAN_DISP_EN_BIT     6
`define ZOOM_MSB            7
`define ZOOM_LSB            6
`define CTL_CURSOR_BIG_BIT  2
`define CTL_OVERLAY_BIT     1
`define CTL_WINDOW_SEL_BIT  0
`define CAP_OVL_EN_BIT      7
`define CAP_INTERLACE_BIT   1
`define CAP_PORT_EN_BIT     0

// Writable masks per register
`define MASK_HIGH_NIBBLE 8'h0f
`define MASK_PAN         8'h07
`define MASK_DEPTH_ZOOM  8'hcf
`define MASK_OVL_CONTROL 8'h07
`define MASK_CAP_CONTROL 8'h83

// Reset values
`define RESET_BYTE       8'h00
`define RESET_INDEX      8'h00

// Pan value that means no shift in 9-dot modes
`define PAN_NINE_DOT_NONE 4'h8

`endif

// ===== ovl_pkg.sv
// Types shared by the overlay register bank files.
// Assumes nothing beyond a SystemVerilog compiler.
package ovl_pkg;

	typedef enum logic [2:0] {
		DEPTH_1  = 3'h0,
		DEPTH_2  = 3'h1,
		DEPTH_4  = 3'h2,
		DEPTH_8  = 3'h3,
		DEPTH_16 = 3'h4,
		DEPTH_RSVD = 3'h7
	} depth_e;

	typedef enum logic [1:0] {
		BUS_IDLE  = 2'h0,
		BUS_INDEX = 2'h1,
		BUS_DATA  = 2'h2
	} bus_target_e;

endpackage

// ===== ovl_decode.sv
// Decodes overlay control fields into display settings.
// Assumes register fields arrive from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ovl_decode (
	// Register fields
	input  wire logic [3:0]    depth_code_i,
	input  wire logic [1:0]    zoom_code_i,
	input  wire logic [2:0]    pan_code_i,
	input  wire logic          nine_dot_i,
	// Decoded settings
	output ovl_pkg::depth_e    depth_o,
	output logic               depth_valid_o,
	output logic [2:0]         line_repeat_o,
	output logic [3:0]         pan_shift_o
);

	always_comb begin
		unique case (depth_code_i)
			4'h0: depth_o = ovl_pkg::DEPTH_1;
			4'h1: depth_o = ovl_pkg::DEPTH_2;
			4'h2: depth_o = ovl_pkg::DEPTH_4;
			4'h3: depth_o = ovl_pkg::DEPTH_8;
			4'h4: depth_o = ovl_pkg::DEPTH_16;
			default: depth_o = ovl_pkg::DEPTH_RSVD;
		endcase
	end

	assign depth_valid_o = (depth_o != ovl_pkg::DEPTH_RSVD);
	// Repeat count 1..4 for zoom 00..11
	assign line_repeat_o = {1'b0, zoom_code_i} + 3'h1;

	// Nine-dot: 8 means none, 0..7 shift 1..8; code 8 needs a 4-bit field
	always_comb begin
		if (nine_dot_i) begin
			pan_shift_o = {1'b0, pan_code_i} + 4'h1;
		end else begin
			pan_shift_o = {1'b0, pan_code_i};
		end
	end

endmodule

`default_nettype wire

// ===== ovl_host.sv
// Host CPU model driving the indexed I/O ports of the register bank.
// Assumes the bank answers one cycle after each strobe it takes.
`timescale 1ns/1ps
`default_nettype none

module ovl_host (
	// Clock
	input  wire logic        clk_i,
	// Answer from the bank
	input  wire logic [7:0]  rdata_i,
	input  wire logic        ack_i,
	// Bus cycle
	output logic [15:0]      addr_o,
	output logic             wr_o,
	output logic             rd_o,
	output logic [7:0]       wdata_o
);
	logic [15:0] base;

	initial begin
		{addr_o, wr_o, rd_o, wdata_o} = '0;
		base = 16'h2150;
	end

	////////////////////////////////////////////////////////////////////////
	// One strobe, then the answer one cycle later
	task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
			output logic [7:0] q, output logic ok);
		@(negedge clk_i);
		addr_o = a;
		wr_o = w;
		rd_o = !w;
		wdata_o = d;
		// Answer stands only in the cycle after the taking edge
		@(negedge clk_i);
		ok = ack_i;
		q = rdata_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Released lines show inverse, not the old value
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	task automatic acc(input logic [7:0] idx, input logic w, input logic [7:0] d,
			output logic [7:0] q, output logic ok);
		logic o1;
		cyc(base | 16'h000a, 1'b1, idx, q, o1);
		cyc(base | 16'h000b, w, d, q, ok);
		ok = ok & o1;
	endtask
endmodule

`default_nettype wire

// ===== ovl_regs_properties.sv
// Port-level checks of the overlay register bank.
// Assumes binding onto ovl_regs with a single clock domain.
`timescale 1ns/1ps
`default_nettype none

module ovl_regs_chk (
	input  wire logic            clk_i,
	input  wire logic            rstn_i,
	input  wire logic [15:0]     io_addr_i,
	input  wire logic            io_wr_i,
	input  wire logic            io_rd_i,
	input  wire logic [7:0]      io_rdata_o,
	input  wire logic            io_ack_o,
	input  wire logic [19:0]     cap_start_dword_o,
	input  wire logic [21:0]     cap_start_byte_o,
	input  wire logic [2:0]      line_repeat_o,
	input  wire ovl_pkg::depth_e depth_o,
	input  wire logic            depth_valid_o,
	input  wire logic            window_sel_o,
	input  wire logic            window_en_o,
	input  wire logic            cursor_en_o,
	input  wire logic            overlay_mode_o,
	input  wire logic [1:0]      cursor_pixel_pins_o,
	input  wire logic            cap_port_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_ack_cause;
		io_ack_o |-> $past(io_wr_i | io_rd_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
	property p_ack_addr;
		io_ack_o |-> $past(io_addr_i[15:8]) == 8'h21 && $past(io_addr_i[3:1]) == 3'h5;
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("ack for foreign port");
	property p_rdata_idle;
		!$past(io_rd_i) |-> io_rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_byte_addr;
		cap_start_byte_o == {cap_start_dword_o, 2'h0};
	endproperty
	a_byte_addr: assert property (p_byte_addr) else $error("byte address wrong");
	property p_repeat;
		line_repeat_o inside {[3'h1:3'h4]};
	endproperty
	a_repeat: assert property (p_repeat) else $error("line repeat range");
	property p_depth;
		depth_valid_o == (depth_o != ovl_pkg::DEPTH_RSVD);
	endproperty
	a_depth: assert property (p_depth) else $error("depth validity");
	property p_enable;
		(window_en_o |-> window_sel_o) and (cursor_en_o |-> !window_sel_o);
	endproperty
	a_enable: assert property (p_enable) else $error("enable of unselected");
	property p_pins;
		overlay_mode_o && $past(overlay_mode_o) |-> cursor_pixel_pins_o == 2'h0;
	endproperty
	a_pins: assert property (p_pins) else $error("cursor pins in overlay");
	property p_port_write;
		$changed(cap_port_en_o) |-> $past(io_wr_i, 2);
	endproperty
	a_port_write: assert property (p_port_write) else $error("port enable moved");
endmodule

bind ovl_regs ovl_regs_chk i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i),
	.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .io_ack_o(io_ack_o),
	.cap_start_dword_o(cap_start_dword_o), .cap_start_byte_o(cap_start_byte_o),
	.line_repeat_o(line_repeat_o), .depth_o(depth_o), .depth_valid_o(depth_valid_o),
	.window_sel_o(window_sel_o), .window_en_o(window_en_o), .cursor_en_o(cursor_en_o),
	.overlay_mode_o(overlay_mode_o), .cursor_pixel_pins_o(cursor_pixel_pins_o),
	.cap_port_en_o(cap_port_en_o));

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the overlay register bank.
// Assumes ovl_host as the I/O bus master; strap value 5.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk_i = 1'b0, rstn_i = 1'b0, den = 1'b0, last = 1'b0, nine = 1'b0, ce = 1'b1;
	logic [1:0] cpx = 2'h0, cpo;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, q;
	logic [2:0] rep;
	logic [3:0] pan;
	logic [11:0] pitch, len, cpitch;
	logic [19:0] sdw;
	logic [21:0] sby;
	logic wr, rd, ack, dval, big, ovl, sel, wen, cen, ilc, pen, ok;
	ovl_pkg::depth_e depth;
	int err_total, tests_run;
	localparam logic [7:0] IDX[14] = '{8'heb, 8'hec, 8'hed, 8'hee, 8'hef, 8'hf0, 8'hf1,
		8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'h80};
	localparam logic [7:0] MSK[14] = '{8'hff, 8'h0f, 8'h07, 8'hcf, 8'h07, 8'hff, 8'hff,
		8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h83, 8'h00};

	ovl_host i_host (.clk_i(clk_i), .rdata_i(rdata), .ack_i(ack), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata));
	ovl_regs i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .io_addr_i(addr),
		.io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata), .io_ack_o(ack),
		.io_base_strap_pins_i(3'h5), .secondary_display_enable_pin_i(den),
		.last_line_i(last), .nine_dot_i(nine), .cursor_pixel_i(cpx),
		.window_pitch_o(pitch), .pan_shift_o(pan), .line_repeat_o(rep), .depth_o(depth),
		.depth_valid_o(dval), .cursor_big_o(big), .overlay_mode_o(ovl),
		.cursor_pixel_pins_o(cpo), .window_sel_o(sel), .window_en_o(wen),
		.cursor_en_o(cen), .cap_start_dword_o(sdw), .cap_start_byte_o(sby),
		.cap_length_o(len), .cap_pitch_o(cpitch), .cap_interlace_o(ilc),
		.cap_port_en_o(pen));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	// Extra cycle lets the settings outputs land
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		i_host.acc(idx, 1'b1, d, q, ok);
		chk(ok, 1);
		@(negedge clk_i);
	endtask

	task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
		i_host.acc(idx, 1'b0, 8'h00, q, ok);
		chk(ok, 1);
		chk(q, exp);
	endtask

	task automatic final_report;
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial forever #50 clk_i = ~clk_i;

	initial begin
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (10) @(negedge clk_i);
		chk({rep, dval, wen, cen, ilc, pen}, 32'h30);
		foreach (IDX[i]) rd_reg(IDX[i], 8'h00);
		foreach (IDX[i]) begin
			wr_reg(IDX[i], 8'hff);
			rd_reg(IDX[i], MSK[i]);
		end
		wr_reg(8'hf0, 8'h45);
		wr_reg(8'hf1, 8'h23);
		wr_reg(8'hf2, 8'hf1);
		chk(sdw, 20'h12345);
		chk(sby, 22'h048d14);
		wr_reg(8'hf3, 8'hbc);
		wr_reg(8'hf4, 8'h0a);
		wr_reg(8'hf5, 8'ha6);
		wr_reg(8'hf6, 8'h05);
		wr_reg(8'heb, 8'hc3);
		wr_reg(8'hec, 8'h09);
		chk(len, 12'habc);
		chk(cpitch, 12'h5a6);
		chk(pitch, 12'h9c3);
		for (int z = 0; z < 4; z++) begin
			for (int d = 0; d < 16; d++) begin
				wr_reg(8'hee, {z[1:0], 2'h0, d[3:0]});
				chk(rep, z + 1);
				chk({dval, depth}, d < 5 ? 8 + d : 7);
			end
		end
		for (int n = 0; n < 2; n++) begin
			nine = n[0];
			for (int p = 0; p < 8; p++) begin
				wr_reg(8'hed, p[7:0]);
				chk(pan, p + n);
			end
		end
		for (int c = 0; c < 16; c++) begin
			cpx = ~c[1:0];
			wr_reg(8'hef, {5'h0, c[0], c[2], c[1]});
			wr_reg(8'hf7, {c[3], 5'h0, c[2], c[1]});
			chk({big, ovl, sel}, {c[0], c[2], c[1]});
			chk({wen, cen}, {c[3] & c[1], c[3] & !c[1]});
			chk({ilc, pen}, c[2:1]);
			chk(cpo, c[2] ? 2'h0 : 2'(~c[1:0]));
		end
		den = 1'b1;
		last = 1'b1;
		wr_reg(8'hed, 8'hfa);
		repeat (5) @(negedge clk_i);
		rd_reg(8'hed, 8'hc2);
		den = 1'b0;
		repeat (5) @(negedge clk_i);
		rd_reg(8'hed, 8'h82);
		// Frozen clock enable must drop the access and keep state
		@(negedge clk_i);
		ce = 1'b0;
		i_host.acc(8'hee, 1'b1, 8'h00, q, ok);
		ce = 1'b1;
		chk({ok, q}, 0);
		rd_reg(8'hee, 8'hcf);
		i_host.base = 16'h2110;
		i_host.acc(8'hef, 1'b0, 8'h00, q, ok);
		chk({ok, q}, 0);
		i_host.base = 16'h2150;
		@(negedge clk_i);
		rstn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (10) @(negedge clk_i);
		chk({wen, cen, ilc, pen}, 0);
		rd_reg(8'hf7, 8'h00);
		final_report();
	end
endmodule

`default_nettype wire
